// >>> hdl/video_decoder_status_bank.sv
// Status and interrupt-B source register bank of the video decoder, Wishbone slave
//
// How it works
// - Ten-bit line count split high/low
// - One sticky source flag per cause
// - Flag holds until host writes reset one
// - Bit five shows command ready live
// - Readable bit mirrors interrupt pin activity
// - Status one shows lock and format
// - Sticky lost-lock flag, cleared by read
// - TV/VCR bit from phase detector
// - Status two weak, field, frozen bits
// - PAL switch caught on odd line one
// - Three-bit copy-protection process code
// - Upper eight bits of front gain
// - Subcarrier phase caught on odd line one
// - Bit seven shows automatic standard mode
// - Detected standard code in bits 3:1
// - Bit zero shows sampling rate
// - Enables gate pin only, not flags
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
`include "video_status_map.svh"

module video_decoder_status_bank
  import video_status_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [11:0]      wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire detector_status_t det_i,
  input  wire logic             init_ready_i,
  input  wire logic             odd_line_one_i,
  output logic                  irq_pin_o,
  output logic                  irq_pin_oe_o
);

  // ==========================================================
  // Declarations
  logic [31:0]  dat_q;
  logic [31:0]  dat_d;
  logic         ack_q;
  logic [7:0]   src_q;
  logic [7:0]   src_d;
  logic [7:0]   enable_q;
  logic         polarity_q;
  logic         lost_q;
  logic         lost_d;
  logic         prime_q;
  logic         pal_switch_q;
  logic [7:0]   phase_q;
  logic         irq_active_q;
  logic         pin_q;
  logic         pin_oe_q;

  wire  [9:0]   word_idx;
  wire          req;
  wire          take;
  wire          rd_take;
  wire          wr_take;
  wire          lane0;
  wire          hit_reset;
  wire          hit_enable;
  wire          hit_config;
  wire          hit_st1;
  wire          rd_st1;
  wire          wr_reset;
  wire          wr_enable;
  wire          wr_config;
  wire  [7:0]   clr_mask;
  wire          hv_lock;
  wire  [7:0]   src_set;
  wire          lock_fall;
  wire          copy_change;
  wire          field_change;
  wire          lalt_change;
  wire          colour_change;
  wire          hv_change;
  wire          tvvcr_change;
  wire          colour_fall;
  wire          hsync_fall;
  wire          vsync_fall;
  wire  [7:0]   src_view;
  wire  [7:0]   line_hi;
  wire  [7:0]   line_lo;
  wire  [7:0]   active_byte;
  wire  [7:0]   st1_byte;
  wire  [7:0]   st2_byte;
  wire  [7:0]   st3_byte;
  wire  [7:0]   st4_byte;
  wire  [7:0]   st5_byte;
  wire  [7:0]   cfg_byte;
  wire  [7:0]   rd_byte;
  wire          irq_active_d;

  // ==========================================================
  // Bus decode
  assign word_idx   = wb_adr_i[11:2];
  assign req        = wb_cyc_i & wb_stb_i;
  // One answer per request; ack drops the cycle after it was given
  assign take       = req & ~ack_q;
  assign rd_take    = take & ~wb_we_i;
  assign wr_take    = take & wb_we_i;
  assign lane0      = wb_sel_i[0];
  assign hit_reset  = (word_idx == `IDX_INT_RESET);
  assign hit_enable = (word_idx == `IDX_INT_ENABLE);
  assign hit_config = (word_idx == `IDX_INT_CONFIG);
  assign hit_st1    = (word_idx == `IDX_STATUS_ONE);
  assign rd_st1     = rd_take & hit_st1;

  // Status indices take no write at all
  assign wr_reset   = wr_take & lane0 & hit_reset;
  assign wr_enable  = wr_take & lane0 & hit_enable;
  assign wr_config  = wr_take & lane0 & hit_config;

  // Writing one clears the matching source flag
  assign clr_mask   = wr_reset ? wb_dat_i[7:0] : 8'h00;

  // ==========================================================
  // Change detection
  assign hv_lock    = det_i.hsync_lock & det_i.vsync_lock;

  // One history per watched level; prime masks the reset values
  level_change #(.W(3)) copy_hist (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .prime_i  (prime_q),
    .level_i  (det_i.copy_process),
    .change_o (copy_change),
    .fall_o   ()
  );
  level_change #(.W(1)) field_hist (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .prime_i  (prime_q),
    .level_i  (det_i.field_50hz),
    .change_o (field_change),
    .fall_o   ()
  );
  level_change #(.W(1)) lalt_hist (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .prime_i  (prime_q),
    .level_i  (det_i.line_alt),
    .change_o (lalt_change),
    .fall_o   ()
  );
  level_change #(.W(1)) colour_hist (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .prime_i  (prime_q),
    .level_i  (det_i.colour_lock),
    .change_o (colour_change),
    .fall_o   (colour_fall)
  );
  level_change #(.W(1)) hv_hist (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .prime_i  (prime_q),
    .level_i  (hv_lock),
    .change_o (hv_change),
    .fall_o   ()
  );
  level_change #(.W(1)) tvvcr_hist (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .prime_i  (prime_q),
    .level_i  (det_i.tv_vcr),
    .change_o (tvvcr_change),
    .fall_o   ()
  );
  level_change #(.W(1)) hsync_hist (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .prime_i  (prime_q),
    .level_i  (det_i.hsync_lock),
    .change_o (),
    .fall_o   (hsync_fall)
  );
  level_change #(.W(1)) vsync_hist (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .prime_i  (prime_q),
    .level_i  (det_i.vsync_lock),
    .change_o (),
    .fall_o   (vsync_fall)
  );

  assign src_set[`SRC_INIT_READY]    = init_ready_i;
  assign src_set[`SRC_COPY_CHANGED]  = copy_change;
  // Command ready is shown live, never stored
  assign src_set[`SRC_CMD_READY]     = 1'b0;
  assign src_set[`SRC_FIELD_CHANGED] = field_change;
  assign src_set[`SRC_LALT_CHANGED]  = lalt_change;
  assign src_set[`SRC_CLOCK_CHANGED] = colour_change;
  assign src_set[`SRC_HV_CHANGED]    = hv_change;
  assign src_set[`SRC_TVVCR_CHANGED] = tvvcr_change;

  // Flags set regardless of enables; set wins over a clear
  assign src_d = (src_q & ~clr_mask) | src_set;

  // Any lock falling since the last read of status one
  assign lock_fall = hsync_fall | vsync_fall | colour_fall;
  assign lost_d = (lost_q & ~rd_st1) | lock_fall;

  // ==========================================================
  // Interrupt pin
  // Enabled source flags decide the pin; bit five never sets, so its enable is inert
  assign irq_active_d = |(src_q & enable_q);

  // ==========================================================
  // Read views
  // Ten-bit count split over two bytes
  assign line_hi = {6'h00, det_i.line_count[9:8]};
  assign line_lo = det_i.line_count[7:0];

  // Command ready is a live level, not a sticky flag
  assign src_view = {src_q[7:6], det_i.cmd_ready, src_q[4:0]};

  // Pin activity seen by software
  assign active_byte = {7'h00, irq_active_q};

  // Lock and format status
  assign st1_byte[`ST1_PEAK_WHITE]  = det_i.peak_white;
  assign st1_byte[`ST1_LINE_ALT]    = det_i.line_alt;
  assign st1_byte[`ST1_FIELD_RATE]  = det_i.field_50hz;
  assign st1_byte[`ST1_LOST_LOCK]   = lost_q;
  assign st1_byte[`ST1_COLOUR_LOCK] = det_i.colour_lock;
  assign st1_byte[`ST1_VSYNC_LOCK]  = det_i.vsync_lock;
  assign st1_byte[`ST1_HSYNC_LOCK]  = det_i.hsync_lock;
  assign st1_byte[`ST1_TV_VCR]      = det_i.tv_vcr;

  // Reserved top bit reads zero
  assign st2_byte = {1'b0, det_i.weak_signal, pal_switch_q, det_i.field_odd,
                     det_i.gain_frozen, det_i.copy_process};

  // Coarse gain only; the two low bits are dropped
  assign st3_byte = det_i.front_gain[9:2];

  // Phase held from the last odd-field line one
  assign st4_byte = phase_q;

  // Mode, standard and rate
  assign st5_byte = {det_i.autoswitch, 3'h0, det_i.standard, det_i.sample_rate_flag};

  assign cfg_byte = {7'h00, polarity_q};

  // Unmapped and write-only indices read zero
  assign rd_byte =
    (word_idx == `IDX_LINE_CNT_HI)  ? line_hi     :
    (word_idx == `IDX_LINE_CNT_LO)  ? line_lo     :
    (word_idx == `IDX_INT_SOURCE)   ? src_view    :
    (word_idx == `IDX_INT_ACTIVE)   ? active_byte :
    hit_st1                         ? st1_byte    :
    (word_idx == `IDX_STATUS_TWO)   ? st2_byte    :
    (word_idx == `IDX_STATUS_THREE) ? st3_byte    :
    (word_idx == `IDX_STATUS_FOUR)  ? st4_byte    :
    (word_idx == `IDX_STATUS_FIVE)  ? st5_byte    :
    hit_enable                      ? enable_q    :
    hit_config                      ? cfg_byte    :
                                      `RST_BYTE;

  assign dat_d = rd_take ? {24'h000000, rd_byte} : 32'h00000000;

  // ==========================================================
  // Bus answer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= take;
      dat_q <= dat_d;
    end
  end

  // ==========================================================
  // Host controls
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_q   <= `RST_ENABLE;
      polarity_q <= `RST_POLARITY;
    end else begin
      if (wr_enable) begin
        enable_q <= wb_dat_i[7:0];
      end
      if (wr_config) begin
        polarity_q <= wb_dat_i[`CFG_POLARITY];
      end
    end
  end

  // ==========================================================
  // Source flags and lost lock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_q  <= 7'h00;
      lost_q <= 1'b0;
    end else begin
      src_q  <= src_d;
      lost_q <= lost_d;
    end
  end

  // ==========================================================
  // Change detection priming
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prime_q <= 1'b0;
    end else begin
      prime_q <= 1'b1;
    end
  end

  // ==========================================================
  // Odd-field line one capture
  // Both values are sampled on the same strobe so they stay consistent
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pal_switch_q <= 1'b0;
      phase_q      <= `RST_PHASE;
    end else if (odd_line_one_i) begin
      pal_switch_q <= det_i.pal_switch;
      phase_q      <= det_i.subcarrier_to_hsync_phase;
    end
  end

  // ==========================================================
  // Pin drive
  // Active low is open drain: drive only while active
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_active_q <= 1'b0;
      pin_q        <= 1'b0;
      pin_oe_q     <= 1'b0;
    end else begin
      irq_active_q <= irq_active_d;
      pin_q        <= polarity_q & irq_active_d;
      pin_oe_q     <= polarity_q | irq_active_d;
    end
  end

  // ==========================================================
  // Outputs
  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = dat_q;
  assign irq_pin_o    = pin_q;
  assign irq_pin_oe_o = pin_oe_q;

endmodule // video_decoder_status_bank

// ==========================================================
// One watched level and its history; prime masks the reset values
module level_change #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         prime_i,
  input  wire logic [W-1:0] level_i,
  output logic              change_o,
  output logic              fall_o
);

  logic [W-1:0] prev_q;

  assign change_o = prime_i & (prev_q != level_i);
  // Fall watches the lowest bit only; meant for single-bit locks
  assign fall_o   = prime_i & prev_q[0] & ~level_i[0];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= '0;
    end else begin
      prev_q <= level_i;
    end
  end

endmodule // level_change

// >>> hdl/video_status_map.svh
// Register indices, field positions, reset values and timing of the video status bank
`ifndef VIDEO_STATUS_MAP_SVH
`define VIDEO_STATUS_MAP_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_INT_RESET      10'h01C
`define IDX_INT_ENABLE     10'h01D
`define IDX_INT_CONFIG     10'h01E
`define IDX_LINE_CNT_HI    10'h084
`define IDX_LINE_CNT_LO    10'h085
`define IDX_INT_SOURCE     10'h086
`define IDX_INT_ACTIVE     10'h087
`define IDX_STATUS_ONE     10'h088
`define IDX_STATUS_TWO     10'h089
`define IDX_STATUS_THREE   10'h08A
`define IDX_STATUS_FOUR    10'h08B
`define IDX_STATUS_FIVE    10'h08C

// ==========================================================
// Interrupt-B source bit positions
`define SRC_INIT_READY     7
`define SRC_COPY_CHANGED   6
`define SRC_CMD_READY      5
`define SRC_FIELD_CHANGED  4
`define SRC_LALT_CHANGED   3
`define SRC_CLOCK_CHANGED  2
`define SRC_HV_CHANGED     1
`define SRC_TVVCR_CHANGED  0

// ==========================================================
// Status register one bit positions
`define ST1_PEAK_WHITE     7
`define ST1_LINE_ALT       6
`define ST1_FIELD_RATE     5
`define ST1_LOST_LOCK      4
`define ST1_COLOUR_LOCK    3
`define ST1_VSYNC_LOCK     2
`define ST1_HSYNC_LOCK     1
`define ST1_TV_VCR         0

// ==========================================================
// Interrupt configuration bit position
`define CFG_POLARITY       0

// ==========================================================
// Reset values
`define RST_BYTE           8'h00
`define RST_ENABLE         8'h00
`define RST_POLARITY       1'b0
`define RST_PHASE          8'h00

// ==========================================================
// Bus answer latency in clock cycles
`define ACK_LATENCY        1

`endif

// >>> hdl/video_status_pkg.sv
// Types shared by the video decoder status bank
package video_status_pkg;

  // ==========================================================
  // Detected copy-protection process
  typedef enum logic [2:0] {
    COPY_NONE        = 3'h0,
    COPY_GAIN        = 3'h1,
    COPY_STRIPE2     = 3'h2,
    COPY_GAIN_STRIPE2 = 3'h3,
    COPY_RSVD4       = 3'h4,
    COPY_RSVD5       = 3'h5,
    COPY_STRIPE3     = 3'h6,
    COPY_GAIN_STRIPE3 = 3'h7
  } copy_process_t;

  // ==========================================================
  // Detected video standard
  typedef enum logic [2:0] {
    STD_NTSC_M   = 3'h0,
    STD_PAL_BGHI = 3'h1,
    STD_PAL_M    = 3'h2,
    STD_PAL_N    = 3'h3,
    STD_NTSC_443 = 3'h4,
    STD_SECAM    = 3'h5,
    STD_RSVD6    = 3'h6,
    STD_RSVD7    = 3'h7
  } video_standard_t;

  // ==========================================================
  // Levels from the sync, colour and gain detectors
  typedef struct packed {
    logic [9:0]      line_count;
    logic [9:0]      front_gain;
    logic [7:0]      subcarrier_to_hsync_phase;
    copy_process_t   copy_process;
    video_standard_t standard;
    logic            peak_white;
    logic            line_alt;
    logic            field_50hz;
    logic            colour_lock;
    logic            vsync_lock;
    logic            hsync_lock;
    logic            tv_vcr;
    logic            weak_signal;
    logic            field_odd;
    logic            gain_frozen;
    logic            pal_switch;
    logic            autoswitch;
    logic            sample_rate_flag;
    logic            cmd_ready;
  } detector_status_t;

endpackage

// >>> tb/video_decoder_status_bank_props.sv
// Bus timing and register read properties of the video status bank
`timescale 1ns/10ps

module video_decoder_status_bank_props
  import video_status_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [11:0]      wb_adr_i,
  input  wire logic [31:0]      wb_dat_o,
  input  wire logic             wb_ack_o,
  input  wire detector_status_t det_i,
  input  wire logic             init_ready_i
);
  // ==========================================================
  // Helpers
  wire logic       take_w  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic       rd_w    = take_w && !wb_we_i;
  wire logic [9:0] lines_w = det_i.line_count;
  wire logic [9:0] gain_w  = det_i.front_gain;
  wire logic       cmd_w   = det_i.cmd_ready;
  wire logic [7:0] st5_w   = {det_i.autoswitch, 3'h0, det_i.standard, det_i.sample_rate_flag};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // Assertions
  a_ack_one_cycle: assert property (take_w |=> wb_ack_o) else $error("ack not one cycle after take");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("data outside ack");
  a_line_high_read: assert property (rd_w && wb_adr_i == 12'h210 |=>
    wb_dat_o == {30'h0, $past(lines_w[9:8])}) else $error("line count high wrong");
  a_gain_upper_read: assert property (rd_w && wb_adr_i == 12'h228 |=>
    wb_dat_o == {24'h0, $past(gain_w[9:2])}) else $error("gain upper bits wrong");
  a_cmd_ready_live: assert property (rd_w && wb_adr_i == 12'h218 |=>
    wb_dat_o[5] == $past(cmd_w)) else $error("command ready bit wrong");
  a_standard_read: assert property (rd_w && wb_adr_i == 12'h230 |=>
    wb_dat_o == {24'h0, $past(st5_w)}) else $error("standard register wrong");
  a_init_flag_set: assert property (init_ready_i ##[1:2] (rd_w && wb_adr_i == 12'h218) |=>
    wb_dat_o[7]) else $error("init ready flag not set");

  // ==========================================================
  // Coverage of main scenarios
  c_status_one_read: cover property (rd_w && wb_adr_i == 12'h220);
  c_flag_clear: cover property (take_w && wb_we_i && wb_adr_i == 12'h070);
  c_init_pulse: cover property (init_ready_i);
endmodule // video_decoder_status_bank_props

bind video_decoder_status_bank video_decoder_status_bank_props u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .det_i(det_i), .init_ready_i(init_ready_i)
);

// >>> tb/video_decoder_status_bank_tb.sv
// Self-checking testbench of the video status bank
`timescale 1ns/10ps

module video_decoder_status_bank_tb;
  import video_status_pkg::*;
  logic             clk_i, rst_n_i, cyc, stb, we, init_ready, odd_line, ack, irq_pin, irq_oe;
  logic [11:0]      adr;
  logic [31:0]      wdat, rdat;
  logic [7:0]       rd;
  detector_status_t det;
  int               errors, checks, cycles;

  video_decoder_status_bank uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .det_i(det),
    .init_ready_i(init_ready), .odd_line_one_i(odd_line), .irq_pin_o(irq_pin), .irq_pin_oe_o(irq_oe)
  );

  // ==========================================================
  // Shared tasks
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic cycle; held until ack is sampled high
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_values;
    bus(0, 12'h218, 8'h00);
    check("source", rd, 8'h00);
    bus(0, 12'h21C, 8'h00);
    check("pin active", rd, 8'h00);
    bus(1, 12'h220, 8'hFF);
    bus(0, 12'h220, 8'h00);
    check("status one", rd, 8'h00);
    bus(0, 12'h3FC, 8'h00);
    check("unmapped", rd, 8'h00);
    $display("t_reset_values done");
  endtask

  task automatic t_levels;
    @(posedge clk_i);
    det.line_count <= 10'h271;
    det.front_gain <= 10'h2D5;
    det.subcarrier_to_hsync_phase <= 8'hA5;
    {det.peak_white, det.field_50hz, det.colour_lock, det.vsync_lock, det.hsync_lock} <= 5'h1F;
    {det.tv_vcr, det.weak_signal, det.field_odd, det.gain_frozen, det.pal_switch} <= 5'h1F;
    det.sample_rate_flag <= 1'b1;
    @(posedge clk_i);
    odd_line <= 1'b1;
    @(posedge clk_i);
    odd_line <= 1'b0;
    // Capture must hold after the strobe is gone
    det.pal_switch <= 1'b0;
    det.subcarrier_to_hsync_phase <= 8'h5A;
    bus(0, 12'h210, 8'h00);
    check("line high", rd, 8'h02);
    bus(0, 12'h214, 8'h00);
    check("line low", rd, 8'h71);
    bus(0, 12'h220, 8'h00);
    check("status one", rd, 8'hAF);
    bus(0, 12'h228, 8'h00);
    check("gain", rd, 8'hB5);
    bus(0, 12'h22C, 8'h00);
    check("phase", rd, 8'hA5);
    for (int c = 0; c < 8; c++) begin
      det.copy_process <= copy_process_t'(c);
      bus(0, 12'h224, 8'h00);
      check("status two", rd, 8'h78 | 8'(c));
    end
    for (int s = 0; s < 8; s++) begin
      det.standard <= video_standard_t'(s);
      det.autoswitch <= s[0];
      bus(0, 12'h230, 8'h00);
      check("status five", rd, {s[0], 3'b000, 3'(s), 1'b1});
    end
    $display("t_levels done");
  endtask

  task automatic t_flags;
    bus(1, 12'h070, 8'hFF);
    det.cmd_ready <= 1'b1;
    bus(0, 12'h218, 8'h00);
    check("source cmd", rd, 8'h20);
    det.field_50hz <= 1'b0;
    repeat (3) @(posedge clk_i);
    bus(0, 12'h218, 8'h00);
    check("source field", rd, 8'h30);
    bus(0, 12'h218, 8'h00);
    check("source held", rd, 8'h30);
    bus(0, 12'h21C, 8'h00);
    check("masked pin", rd, 8'h00);
    bus(1, 12'h074, 8'h10);
    repeat (3) @(posedge clk_i);
    bus(0, 12'h21C, 8'h00);
    check("pin active", rd, 8'h01);
    check("pin low drive", {6'h00, irq_oe, irq_pin}, 8'h02);
    bus(1, 12'h078, 8'h01);
    repeat (3) @(posedge clk_i);
    check("pin high drive", {6'h00, irq_oe, irq_pin}, 8'h03);
    bus(1, 12'h070, 8'h10);
    repeat (3) @(posedge clk_i);
    bus(0, 12'h218, 8'h00);
    check("source cleared", rd, 8'h20);
    check("pin inactive", {6'h00, irq_oe, irq_pin}, 8'h02);
    init_ready <= 1'b1;
    @(posedge clk_i);
    init_ready <= 1'b0;
    bus(0, 12'h218, 8'h00);
    check("source init", rd, 8'hA0);
    $display("t_flags done");
  endtask

  task automatic t_lost_lock;
    bus(0, 12'h220, 8'h00);
    det.hsync_lock <= 1'b0;
    @(posedge clk_i);
    det.hsync_lock <= 1'b1;
    repeat (2) @(posedge clk_i);
    bus(0, 12'h220, 8'h00);
    check("lost lock", rd, 8'h9F);
    bus(0, 12'h220, 8'h00);
    check("lost lock read", rd, 8'h8F);
    $display("t_lost_lock done");
  endtask

  task automatic t_causes;
    bus(1, 12'h070, 8'hFF);
    det.line_alt <= 1'b1;
    det.copy_process <= COPY_GAIN;
    det.tv_vcr <= 1'b0;
    repeat (2) @(posedge clk_i);
    bus(0, 12'h218, 8'h00);
    check("source causes", rd, 8'h69);
    bus(0, 12'h220, 8'h00);
    check("status one alt", rd, 8'hCE);
    bus(1, 12'h070, 8'hFF);
    det.colour_lock <= 1'b0;
    det.vsync_lock <= 1'b0;
    det.cmd_ready <= 1'b0;
    repeat (2) @(posedge clk_i);
    bus(0, 12'h218, 8'h00);
    check("source locks", rd, 8'h06);
    bus(0, 12'h220, 8'h00);
    check("status one lost", rd, 8'hD2);
    bus(1, 12'h074, 8'h06);
    repeat (2) @(posedge clk_i);
    check("pin lock causes", {6'h00, irq_oe, irq_pin}, 8'h03);
    $display("t_causes done");
  endtask

  // ==========================================================
  // Clock, timeout and main sequence
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Generous ceiling; the whole run needs a few hundred cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      print_verdict;
    end
  end

  initial begin
    {rst_n_i, cyc, stb, we, init_ready, odd_line} = 6'h00;
    adr = 12'h000;
    wdat = 32'h0000_0000;
    det = '0;
    errors = 0;
    checks = 0;
    cycles = 0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset_values;
    t_levels;
    t_flags;
    t_lost_lock;
    t_causes;
    print_verdict;
  end
endmodule // video_decoder_status_bank_tb
